// ### shared/led_core_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and 32-bit aligned register words
`ifndef LED_CORE_REGS_SVH
`define LED_CORE_REGS_SVH

// byte addresses of the register words
`define ADDR_ENABLE 8'h00
`define ADDR_MODEB 8'h04
`define ADDR_BRIGHT0 8'h08
`define ADDR_GRPDUTY 8'h28
`define ADDR_GRPFREQ 8'h2c
`define ADDR_ERRFLAGS 8'h30
`define ADDR_STATUS 8'h34

// second mode register fields
`define MODEB_OTCLR_BIT 7
`define MODEB_BLINK_BIT 5
`define MODEB_GROUP_BIT 4
`define MODEB_MASK 8'hb0

// all registers come up as zero
`define REG_RST 8'h00

// reset call byte values
`define CALL_ADDR_BYTE 8'h96
`define CALL_DATA1 8'ha5
`define CALL_DATA2 8'h5a

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// timing
`define CLK_PERIOD_NS 8
`define PWM_STEP_NS 40
`define PWM_STEP_CYC (`PWM_STEP_NS / `CLK_PERIOD_NS)
`define DIM_STEP_NS 20480
`define DIM_STEP_CYC (`DIM_STEP_NS / `CLK_PERIOD_NS)
`define BLINK_LONG_US 64'd10730000
`define BLINK_STEP_CYC ((`BLINK_LONG_US * 64'd1000) / 64'd524288)

`endif

// ### shared/led_core_pkg.sv
// shared types of the led driver control core
// assumes nothing beyond a SystemVerilog tool
`default_nettype none
package led_core_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        CALL_IDLE = 3'b000,
        CALL_ADDR = 3'b001,
        CALL_BYTE1 = 3'b010,
        CALL_BYTE2 = 3'b011,
        CALL_ARMED = 3'b100,
        CALL_IGNORE = 3'b101
    } call_state_e;
endpackage : led_core_pkg
`default_nettype wire

// ### logic/soft_reset_call.sv
// watcher of the bus reset call sequence on the two-wire bus
// assumes raw bus pins from outside the clock domain
`include "led_core_regs.svh"
`default_nettype none
module soft_reset_call (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOe,
    output logic resetCall
);
    logic sclM, sclS, sclQ, sdaM, sdaS, sdaQ;
    logic [3:0] bitCnt, next_bitCnt;
    led_core_pkg::byte_t shiftReg, next_shiftReg;
    led_core_pkg::call_state_e state, next_state;
    logic next_sdaOe, next_resetCall, match, rise, fall, start, stop;

    // two-stage synchronisers, then a history stage for edges
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {sclM, sclS, sclQ} <= 3'b111;
            {sdaM, sdaS, sdaQ} <= 3'b111;
        end else begin
            {sclM, sclS, sclQ} <= {sclPin, sclM, sclS};
            {sdaM, sdaS, sdaQ} <= {sdaPin, sdaM, sdaS};
        end
    end

    assign rise = sclS & ~sclQ;
    assign fall = ~sclS & sclQ;
    assign start = sclS & sclQ & sdaQ & ~sdaS;
    assign stop = sclS & sclQ & ~sdaQ & sdaS;
    assign sdaOut = 1'b0;

    // byte expected at each step of the call
    always_comb begin
        case (state)
            led_core_pkg::CALL_ADDR: match = shiftReg == `CALL_ADDR_BYTE;
            led_core_pkg::CALL_BYTE1: match = shiftReg == `CALL_DATA1;
            led_core_pkg::CALL_BYTE2: match = shiftReg == `CALL_DATA2;
            default: match = 1'b0;
        endcase
    end

    // sequence tracking, acknowledge drive and reset pulse
    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_sdaOe = sdaOe;
        next_resetCall = 1'b0;
        if (start) begin
            next_state = led_core_pkg::CALL_ADDR;
            next_bitCnt = 4'd0;
            next_sdaOe = 1'b0;
        end else if (stop) begin
            next_resetCall = state == led_core_pkg::CALL_ARMED;
            next_state = led_core_pkg::CALL_IDLE;
            next_sdaOe = 1'b0;
        end else if (state != led_core_pkg::CALL_IDLE &&
                     state != led_core_pkg::CALL_IGNORE) begin
            if (rise && bitCnt < 4'd8) begin
                next_shiftReg = {shiftReg[6:0], sdaS};
                next_bitCnt = bitCnt + 4'd1;
            end else if (fall && bitCnt == 4'd8) begin
                next_sdaOe = match;
                next_bitCnt = 4'd9;
            end else if (fall && bitCnt == 4'd9) begin
                next_sdaOe = 1'b0;
                next_bitCnt = 4'd0;
                if (!sdaOe) begin
                    next_state = led_core_pkg::CALL_IGNORE;
                end else begin
                    case (state)
                        led_core_pkg::CALL_ADDR:
                            next_state = led_core_pkg::CALL_BYTE1;
                        led_core_pkg::CALL_BYTE1:
                            next_state = led_core_pkg::CALL_BYTE2;
                        default: next_state = led_core_pkg::CALL_ARMED;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= led_core_pkg::CALL_IDLE;
            bitCnt <= 4'd0;
            shiftReg <= `REG_RST;
            sdaOe <= 1'b0;
            resetCall <= 1'b0;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            sdaOe <= next_sdaOe;
            resetCall <= next_resetCall;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_NO_EXTRA_ACK: assert property (
        state == led_core_pkg::CALL_ARMED && fall && bitCnt == 4'd8
        |=> !sdaOe) else $error("byte after the second was acknowledged");
    AST_ADDR_ACK: assert property (
        state == led_core_pkg::CALL_ADDR && fall && bitCnt == 4'd8
        && !start && !stop |=> sdaOe == $past(shiftReg == 8'h96))
        else $error("call address acknowledge wrong");
    AST_NO_BAD_RESET: assert property (
        stop && state != led_core_pkg::CALL_ARMED |=> !resetCall)
        else $error("reset after a malformed call");
endmodule : soft_reset_call
`default_nettype wire

// ### logic/led_sink_driver_control_core.sv
// control core of an eight-channel led sink driver: pwm, group
// dimming or blinking, error flags and the bus reset call
// assumes an AXI4-Lite master on mclk, raw bus pins and async fault
// inputs from the analog side
//
// Contract
// - enabled channel flags 0 on open load, 1 when normal
// - global overtemperature turns all channels off, records 0 in each
// - channels restart after cooling; recorded error stays readable
// - channel overtemperature turns off and flags only that channel
// - channel overtemperature counts only while the channel is on
// - open load and overtemperature merge into one flag per channel
// - mode bit 7 at 1 clears overtemperature errors; 0 re-enables
// - power-on reset zeroes registers and bus logic, channels off
// - while reset pin is low everything stays at defaults
// - acknowledge reset call address 96h only, never with read bit
// - acknowledge first call byte only when it is A5h
// - acknowledge second call byte only when it is 5Ah
// - no acknowledge for any byte after the second
// - after correct call and stop, reset to power-up values
// - malformed call leaves registers alone
// - each output has its own 97 kHz pwm, 256 duty steps
// - optional 190 Hz group duty signal gates all outputs
// - alternative group blink with period set in 256 steps
// - brightness pulse is n times 40 ns
// - group dimming step is 20.48 us
// - group duty 1 passes exactly two brightness pulses
// - standby when all channels are off, active otherwise
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "led_core_regs.svh"
`default_nettype none
module led_sink_driver_control_core #(
    parameter int CHANNELS = 8,
    parameter int BLINK_STEP_CYCLES = int'(`BLINK_STEP_CYC)
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [CHANNELS-1:0] openLoadPin,
    input wire logic [CHANNELS-1:0] chanHotPin,
    input wire logic globalHotPin,
    output logic [CHANNELS-1:0] ledDrive,
    output logic standby
);
    localparam int SW = 2 * CHANNELS + 1;

    // settings
    logic [CHANNELS-1:0] ledEnable, next_ledEnable;
    led_core_pkg::byte_t modeB, next_modeB;
    led_core_pkg::byte_t bright [CHANNELS];
    led_core_pkg::byte_t next_bright [CHANNELS];
    led_core_pkg::byte_t grpDuty, next_grpDuty, grpFreq, next_grpFreq;
    // bus slave
    logic awHeld, next_awHeld, wHeld, next_wHeld;
    logic [7:0] awAddr, next_awAddr;
    led_core_pkg::byte_t wData, next_wData;
    logic wStrb0, next_wStrb0, next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic haveAw, haveW, doWrite, wrStrb;
    logic [7:0] wrAddr;
    led_core_pkg::byte_t wrData;
    // timing
    logic [2:0] stepDiv, next_stepDiv;
    led_core_pkg::byte_t pwmCnt, next_pwmCnt, grpCnt, next_grpCnt;
    led_core_pkg::byte_t grpSub, next_grpSub;
    logic [15:0] grpPre, next_grpPre, preLimit;
    logic stepTick, preTick, subDone, grpTick, groupOn;
    // faults
    logic [SW-1:0] faultM, faultS;
    logic [CHANNELS-1:0] openLoadS, chanHotS, otErr, next_otErr;
    logic [CHANNELS-1:0] next_ledDrive, errFlags;
    logic globalHotS, resetCall, otClr, blinkMode, groupUse;

    assign otClr = modeB[`MODEB_OTCLR_BIT];
    assign blinkMode = modeB[`MODEB_BLINK_BIT];
    assign groupUse = modeB[`MODEB_GROUP_BIT];

    // reset call watcher on the serial bus pins
    soft_reset_call u_call (
        .mclk(mclk),
        .rst_b(rst_b),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .resetCall(resetCall)
    );

    // analog fault inputs cross through two flip-flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            faultM <= '0;
            faultS <= '0;
        end else begin
            faultM <= {globalHotPin, chanHotPin, openLoadPin};
            faultS <= faultM;
        end
    end
    assign openLoadS = faultS[CHANNELS-1:0];
    assign chanHotS = faultS[2*CHANNELS-1:CHANNELS];
    assign globalHotS = faultS[SW-1];

    // write channel pairing: address and data in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign haveAw = awHeld || (s_axi_awvalid && s_axi_awready);
    assign haveW = wHeld || (s_axi_wvalid && s_axi_wready);
    assign doWrite = haveAw && haveW;
    assign wrAddr = awHeld ? awAddr : {s_axi_awaddr[7:2], 2'b00};
    assign wrData = wHeld ? wData : s_axi_wdata[7:0];
    assign wrStrb = wHeld ? wStrb0 : s_axi_wstrb[0];
    assign s_axi_arready = !s_axi_rvalid;

    // brightness window decode
    function automatic logic isBright(input logic [7:0] a);
        logic [7:0] off;
        off = 8'(a - `ADDR_BRIGHT0);
        isBright = a >= `ADDR_BRIGHT0 && off[7:2] < 6'(CHANNELS);
    endfunction : isBright

    function automatic logic [2:0] brIndex(input logic [7:0] a);
        logic [7:0] off;
        off = 8'(a - `ADDR_BRIGHT0);
        brIndex = off[4:2];
    endfunction : brIndex

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = isBright(a) || a == `ADDR_ENABLE || a == `ADDR_MODEB
            || a == `ADDR_GRPDUTY || a == `ADDR_GRPFREQ
            || a == `ADDR_ERRFLAGS || a == `ADDR_STATUS;
    endfunction : isMapped

    // bus slave handshake state
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb0 = wStrb0;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata[7:0];
            next_wStrb0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = isMapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = isMapped({s_axi_araddr[7:2], 2'b00})
                ? `RESP_OKAY : `RESP_SLVERR;
            next_rdata = 32'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                `ADDR_ENABLE: next_rdata[CHANNELS-1:0] = ledEnable;
                `ADDR_MODEB: next_rdata[7:0] = modeB;
                `ADDR_GRPDUTY: next_rdata[7:0] = grpDuty;
                `ADDR_GRPFREQ: next_rdata[7:0] = grpFreq;
                `ADDR_ERRFLAGS: next_rdata[CHANNELS-1:0] = errFlags;
                `ADDR_STATUS: next_rdata[1:0] = {globalHotS, !standby};
                default: if (isBright({s_axi_araddr[7:2], 2'b00})) begin
                    next_rdata[7:0] =
                        bright[brIndex({s_axi_araddr[7:2], 2'b00})];
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= `REG_RST;
            wStrb0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb0 <= next_wStrb0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // settings: software writes, reset call returns all to zero
    always_comb begin
        next_ledEnable = ledEnable;
        next_modeB = modeB;
        next_grpDuty = grpDuty;
        next_grpFreq = grpFreq;
        for (int i = 0; i < CHANNELS; i++) begin
            next_bright[i] = bright[i];
        end
        if (resetCall) begin
            next_ledEnable = '0;
            next_modeB = `REG_RST;
            next_grpDuty = `REG_RST;
            next_grpFreq = `REG_RST;
            for (int i = 0; i < CHANNELS; i++) begin
                next_bright[i] = `REG_RST;
            end
        end else if (doWrite && wrStrb) begin
            case (wrAddr)
                `ADDR_ENABLE: next_ledEnable = wrData[CHANNELS-1:0];
                `ADDR_MODEB: next_modeB = wrData & `MODEB_MASK;
                `ADDR_GRPDUTY: next_grpDuty = wrData;
                `ADDR_GRPFREQ: next_grpFreq = wrData;
                default: if (isBright(wrAddr)) begin
                    next_bright[brIndex(wrAddr)] = wrData;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ledEnable <= '0;
            modeB <= `REG_RST;
            grpDuty <= `REG_RST;
            grpFreq <= `REG_RST;
            for (int i = 0; i < CHANNELS; i++) begin
                bright[i] <= `REG_RST;
            end
        end else begin
            ledEnable <= next_ledEnable;
            modeB <= next_modeB;
            grpDuty <= next_grpDuty;
            grpFreq <= next_grpFreq;
            for (int i = 0; i < CHANNELS; i++) begin
                bright[i] <= next_bright[i];
            end
        end
    end

    // 40 ns step, brightness counter and group counter
    assign stepTick = stepDiv == 3'(`PWM_STEP_CYC - 1);
    assign preLimit = blinkMode ? 16'(BLINK_STEP_CYCLES - 1)
        : 16'(`DIM_STEP_CYC - 1);
    assign preTick = grpPre >= preLimit;
    assign subDone = !blinkMode || grpSub >= grpFreq;
    assign grpTick = preTick && subDone;
    assign groupOn = grpCnt < grpDuty;

    always_comb begin
        next_stepDiv = stepTick ? 3'd0 : 3'(stepDiv + 3'd1);
        next_pwmCnt = 8'(pwmCnt + {7'd0, stepTick});
        next_grpPre = preTick ? 16'd0 : 16'(grpPre + 16'd1);
        next_grpSub = grpSub;
        if (preTick) begin
            next_grpSub = subDone ? 8'd0 : 8'(grpSub + 8'd1);
        end
        next_grpCnt = 8'(grpCnt + {7'd0, grpTick});
        if (resetCall) begin
            next_stepDiv = 3'd0;
            next_pwmCnt = 8'd0;
            next_grpPre = 16'd0;
            next_grpSub = 8'd0;
            next_grpCnt = 8'd0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stepDiv <= 3'd0;
            pwmCnt <= 8'd0;
            grpPre <= 16'd0;
            grpSub <= 8'd0;
            grpCnt <= 8'd0;
        end else begin
            stepDiv <= next_stepDiv;
            pwmCnt <= next_pwmCnt;
            grpPre <= next_grpPre;
            grpSub <= next_grpSub;
            grpCnt <= next_grpCnt;
        end
    end

    // per channel drive, sticky overtemperature record and flag
    for (genvar g = 0; g < CHANNELS; g++) begin : gen_ch
        assign next_ledDrive[g] = ledEnable[g] && !globalHotS
            && !chanHotS[g]
            && pwmCnt < bright[g]
            && (groupOn || !groupUse);
        assign next_otErr[g] = !otClr && (otErr[g] || globalHotS
            || (chanHotS[g] && ledEnable[g]));
        assign errFlags[g] = ledEnable[g] && !openLoadS[g]
            && !otErr[g];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ledDrive <= '0;
            otErr <= '0;
        end else begin
            ledDrive <= resetCall ? '0 : next_ledDrive;
            otErr <= resetCall ? '0 : next_otErr;
        end
    end

    // standby whenever no channel is enabled
    assign standby = ledEnable == '0;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_OPEN_FLAG: assert property (
        ledEnable[0] && openLoadS[0] |-> !errFlags[0])
        else $error("open load not flagged");
    AST_GLOBAL_OFF: assert property (
        globalHotS |=> ledDrive == '0)
        else $error("outputs on during global overtemperature");
    AST_GLOBAL_ERR: assert property (
        globalHotS && !otClr ##1 !otClr |-> errFlags == '0)
        else $error("global overtemperature not recorded");
    AST_STICKY: assert property (
        otErr[0] && !otClr && !resetCall |=> otErr[0])
        else $error("overtemperature record lost after cooling");
    AST_CHAN_OFF: assert property (
        chanHotS[1] |=> !ledDrive[1])
        else $error("hot channel still driven");
    AST_OFF_NO_ERR: assert property (
        chanHotS[2] && !ledEnable[2] && !globalHotS && !otErr[2]
        |=> !otErr[2]) else $error("off channel recorded overtemperature");
    AST_OT_CLEAR: assert property (
        otClr |=> otErr == '0) else $error("overtemperature clear ignored");
    AST_CALL_RESET: assert property (
        resetCall |=> ledEnable == '0 && grpDuty == 8'h00 && modeB == 8'h00)
        else $error("reset call left settings");
    AST_STEP_40NS: assert property (
        disable iff (!rst_b || resetCall)
        stepTick |=> !stepTick [*4] ##1 stepTick)
        else $error("brightness step not 40 ns");
    AST_DIM_STEP: assert property (
        grpTick && !blinkMode |=> !grpTick [*8])
        else $error("dimming step too short");
    AST_STANDBY: assert property (
        standby |-> ledDrive == '0 || $past(ledEnable) != '0)
        else $error("output on in standby");
endmodule : led_sink_driver_control_core
`default_nettype wire

// ### verification/i2c_master_model.sv
// two-wire bus master model that sends the reset call frames
// assumes an open-drain data line with pull-up resolved by the bench
`default_nettype none
module i2c_master_model (
    output logic scl,
    output logic sdaLow,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 1ns;
    // both lines released, clock still outside frames
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // data falls while clock high, then clock low
    task automatic start();
        sdaLow = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask : start
    // eight bits msb first, then a released ack clock
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic [8:0] s;
        s = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            sdaLow = !s[i];
            #40 scl = 1'b1;
            #40 ack = !sdaLine;
            #40 scl = 1'b0;
            #40;
        end
    endtask : sendByte
    // data rises while clock high
    task automatic stop();
        sdaLow = 1'b1;
        #40 scl = 1'b1;
        #40 sdaLow = 1'b0;
        #80;
    endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// ### verification/led_sink_driver_control_core_tb.sv
// self-checking bench of the led driver control core
// assumes the bus master model beside it on the two-wire bus
`include "led_core_regs.svh"
`default_nettype none
module led_sink_driver_control_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b, scl, sdaLow, sdaOut, sdaOe, standby, globalHotPin;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, openLoadPin, chanHotPin, ledDrive;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int miscompares = 0, nChecks = 0, cyc = 0;
    // open-drain data line, pulled up
    wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));
    led_sink_driver_control_core #(.BLINK_STEP_CYCLES(4))
        led_sink_driver_control_core_i (.mclk, .rst_b, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sclPin(scl), .sdaPin(sdaLine), .sdaOut, .sdaOe, .openLoadPin,
        .chanHotPin, .globalHotPin, .ledDrive, .standby);
    i2c_master_model i2c_master_model_i (.scl, .sdaLow, .sdaLine);
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #4 mclk = !mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [31:0] e, g);
        nChecks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    // one register bus transfer
    task automatic axi(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        logic hA, hW, hB;
        @(posedge mclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (int n = 0; n < 40; n++) begin
            @(negedge mclk);
            hA = wr ? s_axi_awready : s_axi_arready;
            hW = s_axi_wready;
            hB = wr ? s_axi_bvalid : s_axi_rvalid;
            {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge mclk);
            if (hA) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (hW) s_axi_wvalid <= 1'b0;
            if (hB) begin
                {s_axi_bready, s_axi_rready} <= 2'b00;
                return;
            end
        end
        chk("bus answer", 32'h1, 32'h0);
    endtask : axi
    // read after fault inputs have crossed the synchroniser
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        repeat (4) @(posedge mclk);
        axi(1'b0, a, 32'h0);
        chk("rdata", e, q);
    endtask : rd
    // lit cycles of one channel over a full pwm period
    task automatic meas(input int ch, input logic [31:0] e);
        logic [31:0] h;
        h = 32'h0;
        repeat (1280) @(posedge mclk);
        repeat (1280) begin
            @(negedge mclk);
            h = h + 32'(ledDrive[ch]);
        end
        @(posedge mclk);
        chk("lit cycles", e, h);
    endtask : meas
    task automatic testDefaults();
        rd(`ADDR_MODEB, 32'h0);
        #1 chk("standby", 32'h1, 32'(standby));
        axi(1'b0, 8'h3c, 32'h0);
        chk("rresp", 32'(`RESP_SLVERR), 32'(r));
        axi(1'b1, `ADDR_ENABLE, 32'hff);
        chk("bresp", 32'(`RESP_OKAY), 32'(r));
        #1 chk("standby", 32'h0, 32'(standby));
        @(posedge mclk) rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("ledDrive", 32'h0, 32'(ledDrive));
        @(posedge mclk) rst_b <= 1'b1;
        rd(`ADDR_ENABLE, 32'h0);
    endtask : testDefaults
    task automatic testPwm();
        axi(1'b1, `ADDR_ENABLE, 32'h1);
        for (int b = 1; b < 256; b += 254) begin
            axi(1'b1, `ADDR_BRIGHT0, 32'(b));
            meas(0, 32'(b * `PWM_STEP_CYC));
        end
        axi(1'b1, `ADDR_MODEB, 32'h10);
        meas(0, 32'h0);
        axi(1'b1, `ADDR_MODEB, 32'h30);
        meas(0, 32'h0);
        axi(1'b1, `ADDR_MODEB, 32'h0);
    endtask : testPwm
    task automatic testFaults();
        axi(1'b1, `ADDR_ENABLE, 32'h3);
        rd(`ADDR_ERRFLAGS, 32'h3);
        openLoadPin <= 8'h01;
        rd(`ADDR_ERRFLAGS, 32'h2);
        openLoadPin <= 8'h00;
        chanHotPin <= 8'h06;
        meas(0, 32'd1275);
        rd(`ADDR_ERRFLAGS, 32'h1);
        chanHotPin <= 8'h00;
        axi(1'b1, `ADDR_ENABLE, 32'h7);
        rd(`ADDR_ERRFLAGS, 32'h5);
        globalHotPin <= 1'b1;
        meas(0, 32'h0);
        rd(`ADDR_ERRFLAGS, 32'h0);
        rd(`ADDR_STATUS, 32'h3);
        globalHotPin <= 1'b0;
        meas(0, 32'd1275);
        rd(`ADDR_ERRFLAGS, 32'h0);
        axi(1'b1, `ADDR_MODEB, 32'h80);
        rd(`ADDR_ERRFLAGS, 32'h7);
        axi(1'b1, `ADDR_MODEB, 32'h0);
        chanHotPin <= 8'h01;
        rd(`ADDR_ERRFLAGS, 32'h6);
        chanHotPin <= 8'h00;
    endtask : testFaults
    // one reset call frame; the enable register shows whether it reset
    task automatic call(input logic [31:0] f, input int n,
        input logic [3:0] acks, input logic [31:0] e);
        logic ack;
        axi(1'b1, `ADDR_ENABLE, 32'h1);
        #1 i2c_master_model_i.start();
        for (int i = 0; i < n; i++) begin
            i2c_master_model_i.sendByte(f[31-8*i -: 8], ack);
            chk("ack", 32'(acks[3-i]), 32'(ack));
        end
        i2c_master_model_i.stop();
        rd(`ADDR_ENABLE, e);
    endtask : call
    task automatic testCalls();
        call(32'h96a55a00, 3, 4'he, 32'h0);
        call(32'h97000000, 1, 4'h0, 32'h1);
        call(32'h96120000, 2, 4'h8, 32'h1);
        call(32'h96a50000, 3, 4'hc, 32'h1);
        call(32'h96a55aa5, 4, 4'he, 32'h1);
        call(32'h96a55a00, 3, 4'he, 32'h0);
    endtask : testCalls
    // reset, then the scenarios
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, globalHotPin} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, openLoadPin, chanHotPin} = 32'h0;
        s_axi_wdata = 32'h0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        testDefaults();
        testPwm();
        testFaults();
        testCalls();
        tally_and_finish();
    end
endmodule : led_sink_driver_control_core_tb
`default_nettype wire
